//--- rtl/nri_regs.svh
`ifndef NRI_REGS_SVH
`define NRI_REGS_SVH
`define NRI_BANK_W 3
`define NRI_ROW_W 16
`define NRI_COL_W 10
`define NRI_CMD_W 3
`define NRI_BUF_W 5
`define NRI_DATA_W 64
`define NRI_MASK_W 8
`define NRI_CMD_WRITE 3'h0
`define NRI_CMD_READ 3'h1
`define NRI_RD_LAT 4'h6
`define NRI_MAINT_CYC 4'h8
`endif

//--- rtl/nri_pkg.sv
package nri_pkg;
  `include "nri_regs.svh"
  typedef logic [`NRI_BUF_W-1:0] nri_buf_t;
  typedef logic [`NRI_DATA_W-1:0] nri_data_t;
  typedef logic [`NRI_MASK_W-1:0] nri_mask_t;
  typedef struct packed {
    logic [`NRI_BANK_W-1:0] bank;
    logic [`NRI_ROW_W-1:0] row;
    logic [`NRI_COL_W-1:0] col;
    logic [`NRI_CMD_W-1:0] cmd;
    nri_buf_t ptr;
  } nri_req_t;
  typedef enum logic [1:0] {
    NRI_IDLE = 2'b00,
    NRI_MAINT = 2'b01
  } nri_state_t;
endpackage

//--- rtl/nri_if.sv
`timescale 1ns/1ps
interface nri_if;
  import nri_pkg::*;
  logic [`NRI_BANK_W-1:0] bank;
  logic [`NRI_ROW_W-1:0] row;
  logic [`NRI_COL_W-1:0] col;
  logic [`NRI_CMD_W-1:0] cmd;
  nri_buf_t buffer_pointer_value;
  logic use_addr;
  logic accept;
  logic write_data_fetch;
  nri_buf_t write_buffer_echo;
  nri_data_t write_payload;
  nri_mask_t write_byte_mask;
  logic read_data_valid;
  nri_buf_t read_buffer_echo;
  nri_data_t read_payload;
  logic refresh_request;
  logic refresh_acknowledge;
  logic calibration_request;
  logic calibration_acknowledge;
  modport ctrl (
    input bank, row, col, cmd, buffer_pointer_value, use_addr, write_payload, write_byte_mask,
    input refresh_request, calibration_request,
    output accept, write_data_fetch, write_buffer_echo, read_data_valid, read_buffer_echo,
    output read_payload, refresh_acknowledge, calibration_acknowledge
  );
  modport user (
    output bank, row, col, cmd, buffer_pointer_value, use_addr, write_payload, write_byte_mask,
    output refresh_request, calibration_request,
    input accept, write_data_fetch, write_buffer_echo, read_data_valid, read_buffer_echo,
    input read_payload, refresh_acknowledge, calibration_acknowledge
  );
endinterface

//--- rtl/nri_ctrl.sv
`timescale 1ns/1ps
// Function
// RULE_01 - Pulse calibration acknowledge once when done
// RULE_02 - Request is bank, row, column, command
// RULE_03 - Address leads valid strobe by one
// RULE_04 - Taken when valid and accept high
// RULE_05 - Refused request is presented again
// RULE_06 - Buffer pointer travels with each request
// RULE_07 - Echo pointer on write or read
// RULE_08 - Write data follows fetch by one
// RULE_09 - Gaps or back-to-back both accepted
// RULE_10 - Read valid marks delivered read data
// RULE_11 - Fetch only while collecting write data
// RULE_12 - Reorder mode completes in processed order
// RULE_13 - User issues one request at a time
// RULE_14 - Read return and write fetch concurrent
// RULE_15 - Calibration pulse pauses work, one per rank
// RULE_16 - Refresh pulse pauses work, one per rank
// RULE_17 - Pulse refresh acknowledge once when done
// RULE_18 - User maintenance only with interval zero
// RULE_19 - User holds request stable until accepted
// RULE_20 - Accept may drop when busy
module nri_ctrl
  import nri_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_reorder_mode,
  nri_if.ctrl bus,
  output logic o_mem_cmd_valid,
  output logic [`NRI_CMD_W-1:0] o_mem_cmd,
  output logic [`NRI_BANK_W-1:0] o_mem_bank,
  output logic [`NRI_ROW_W-1:0] o_mem_row,
  output logic [`NRI_COL_W-1:0] o_mem_col,
  output logic o_mem_wr_valid,
  output nri_data_t o_mem_wr_data,
  output nri_mask_t o_mem_wr_mask,
  input wire logic i_mem_rd_valid,
  input wire nri_data_t i_mem_rd_data
);
  // Two-entry request buffer
  nri_req_t buf_r [2];
  logic [1:0] buf_v_r;
  logic [1:0] buf_v_nxt;
  logic rd_idx_r;
  nri_state_t state_r;
  nri_state_t state_nxt;
  logic [3:0] maint_cnt_r;
  logic ref_pend_r;
  logic cal_pend_r;
  // Read pointer queue, returned in processed order
  nri_buf_t rq_r [8];
  logic [2:0] rq_wp_r;
  logic [2:0] rq_rp_r;
  logic wfetch_d_r;
  logic accept_r;
  logic wdf_r;
  nri_buf_t wbe_r;
  logic rdv_r;
  nri_buf_t rbe_r;
  nri_data_t rpl_r;
  logic rack_r;
  logic cack_r;
  logic cmd_v_r;
  logic [`NRI_CMD_W-1:0] cmd_r;
  logic [`NRI_BANK_W-1:0] bank_r;
  logic [`NRI_ROW_W-1:0] row_r;
  logic [`NRI_COL_W-1:0] col_r;
  logic mwv_r;
  nri_data_t mwd_r;
  nri_mask_t mwm_r;
  // Request capture
  wire take = bus.use_addr & accept_r;
  wire full = buf_v_r[0] & buf_v_r[1];
  // New entry fills the oldest slot if free, else the other one
  wire wslot = buf_v_r[rd_idx_r] ? ~rd_idx_r : rd_idx_r;
  wire maint_go = bus.refresh_request | bus.calibration_request;
  // Issue choice: in reorder mode prefer the newer entry when it hits the open row and the same-bank older entry misses
  wire older = rd_idx_r;
  wire newer = ~rd_idx_r;
  wire swap = i_reorder_mode & buf_v_r[older] & buf_v_r[newer] &
    (buf_r[older].bank == buf_r[newer].bank) & (buf_r[older].row != row_r) &
    (buf_r[newer].row == row_r);
  wire sel = swap ? newer : older;
  wire issue = (state_r == NRI_IDLE) & buf_v_r[sel] & ~maint_go & ~ref_pend_r & ~cal_pend_r;
  wire issue_wr = issue & (buf_r[sel].cmd == `NRI_CMD_WRITE);
  wire issue_rd = issue & (buf_r[sel].cmd == `NRI_CMD_READ);
  wire maint_done = (state_r == NRI_MAINT) & (maint_cnt_r == 4'h0);
  wire [3:0] maint_len = `NRI_MAINT_CYC;
  always_comb begin
    buf_v_nxt = buf_v_r;
    if (issue) begin
      buf_v_nxt[sel] = 1'b0;
    end
    if (take) begin
      buf_v_nxt[wslot] = 1'b1;
    end
  end
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      NRI_IDLE: begin
        if (maint_go | ref_pend_r | cal_pend_r) begin
          state_nxt = NRI_MAINT;
        end
      end
      NRI_MAINT: begin
        if (maint_done) begin
          state_nxt = NRI_IDLE;
        end
      end
      default: begin
        state_nxt = NRI_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      buf_v_r <= 2'h0;
      rd_idx_r <= 1'b0;
      state_r <= NRI_IDLE;
      maint_cnt_r <= 4'h0;
      ref_pend_r <= 1'b0;
      cal_pend_r <= 1'b0;
      accept_r <= 1'b0;
    end else begin
      // RULE_04 capture on handshake
      buf_v_r <= buf_v_nxt;
      // RULE_12 oldest slot advances after the older entry issues
      if (issue & (sel == older)) begin
        rd_idx_r <= ~rd_idx_r;
      end
      state_r <= state_nxt;
      // RULE_15 RULE_16 maintenance pause
      if (state_r == NRI_IDLE && state_nxt == NRI_MAINT) begin
        maint_cnt_r <= maint_len;
      end else if (maint_cnt_r != 4'h0) begin
        maint_cnt_r <= maint_cnt_r - 4'h1;
      end
      if (bus.refresh_request) begin
        ref_pend_r <= 1'b1;
      end else if (maint_done) begin
        ref_pend_r <= 1'b0;
      end
      if (bus.calibration_request) begin
        cal_pend_r <= 1'b1;
      end else if (maint_done) begin
        cal_pend_r <= 1'b0;
      end
      // RULE_20 RULE_09 accept tracks free space
      accept_r <= (state_nxt == NRI_IDLE) & ~maint_go & ~(buf_v_nxt[0] & buf_v_nxt[1]) & ~(full & ~issue);
    end
  end
  always_ff @(posedge i_clk_sys) begin
    // RULE_06 pointer stored with request
    if (take) begin
      buf_r[wslot] <= '{bus.bank, bus.row, bus.col, bus.cmd, bus.buffer_pointer_value};
    end
    if (issue_rd) begin
      rq_r[rq_wp_r] <= buf_r[sel].ptr;
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rq_wp_r <= 3'h0;
      rq_rp_r <= 3'h0;
      wfetch_d_r <= 1'b0;
      wdf_r <= 1'b0;
      wbe_r <= '0;
      rdv_r <= 1'b0;
      rbe_r <= '0;
      rpl_r <= '0;
      rack_r <= 1'b0;
      cack_r <= 1'b0;
      cmd_v_r <= 1'b0;
      cmd_r <= '0;
      bank_r <= '0;
      row_r <= '0;
      col_r <= '0;
      mwv_r <= 1'b0;
      mwd_r <= '0;
      mwm_r <= '0;
    end else begin
      // RULE_14 command issue, write fetch and read return proceed concurrently
      cmd_v_r <= issue;
      if (issue) begin
        cmd_r <= buf_r[sel].cmd;
        bank_r <= buf_r[sel].bank;
        row_r <= buf_r[sel].row;
        col_r <= buf_r[sel].col;
      end
      // RULE_07 RULE_11 write fetch with echo
      wdf_r <= issue_wr;
      if (issue_wr) begin
        wbe_r <= buf_r[sel].ptr;
      end
      // RULE_08 data taken cycle after fetch
      wfetch_d_r <= wdf_r;
      mwv_r <= wfetch_d_r;
      if (wfetch_d_r) begin
        mwd_r <= bus.write_payload;
        mwm_r <= bus.write_byte_mask;
      end
      if (issue_rd) begin
        rq_wp_r <= rq_wp_r + 3'h1;
      end
      // RULE_10 RULE_07 read return with echo
      rdv_r <= i_mem_rd_valid;
      if (i_mem_rd_valid) begin
        rbe_r <= rq_r[rq_rp_r];
        rpl_r <= i_mem_rd_data;
        rq_rp_r <= rq_rp_r + 3'h1;
      end
      // RULE_17 RULE_01 one-cycle acknowledges
      rack_r <= maint_done & ref_pend_r;
      cack_r <= maint_done & cal_pend_r;
    end
  end
  assign bus.accept = accept_r;
  assign bus.write_data_fetch = wdf_r;
  assign bus.write_buffer_echo = wbe_r;
  assign bus.read_data_valid = rdv_r;
  assign bus.read_buffer_echo = rbe_r;
  assign bus.read_payload = rpl_r;
  assign bus.refresh_acknowledge = rack_r;
  assign bus.calibration_acknowledge = cack_r;
  assign o_mem_cmd_valid = cmd_v_r;
  assign o_mem_cmd = cmd_r;
  assign o_mem_bank = bank_r;
  assign o_mem_row = row_r;
  assign o_mem_col = col_r;
  assign o_mem_wr_valid = mwv_r;
  assign o_mem_wr_data = mwd_r;
  assign o_mem_wr_mask = mwm_r;
endmodule

//--- rtl/nri_user.sv
`timescale 1ns/1ps
module nri_user
  import nri_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  nri_if.user bus,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire nri_req_t i_req,
  input wire logic i_refresh,
  input wire logic i_calibrate,
  output logic o_maint_busy,
  output logic o_fetch,
  output nri_buf_t o_fetch_ptr,
  input wire nri_data_t i_wr_data,
  input wire nri_mask_t i_wr_mask,
  output logic o_rd_valid,
  output nri_buf_t o_rd_ptr,
  output nri_data_t o_rd_data
);
  nri_req_t cur_r;
  logic pend_r;
  logic vld_r;
  logic ref_r;
  logic cal_r;
  logic busy_r;
  logic ref_out_r;
  logic cal_out_r;
  logic fetch_r;
  nri_buf_t fptr_r;
  nri_data_t wd_r;
  nri_mask_t wm_r;
  logic rv_r;
  nri_buf_t rp_r;
  nri_data_t rdat_r;
  logic ready_r;
  wire done = vld_r & bus.accept;
  wire load = i_req_valid & ready_r;
  wire maint_ok = ~pend_r & ~busy_r;
  wire ack = bus.refresh_acknowledge | bus.calibration_acknowledge;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cur_r <= '0;
      pend_r <= 1'b0;
      vld_r <= 1'b0;
      ready_r <= 1'b0;
      ref_r <= 1'b0;
      cal_r <= 1'b0;
      busy_r <= 1'b0;
      ref_out_r <= 1'b0;
      cal_out_r <= 1'b0;
      fetch_r <= 1'b0;
      fptr_r <= '0;
      wd_r <= '0;
      wm_r <= '0;
      rv_r <= 1'b0;
      rp_r <= '0;
      rdat_r <= '0;
    end else begin
      // RULE_02 RULE_06 RULE_19 hold request
      if (load) begin
        cur_r <= i_req;
      end
      // RULE_03 valid one cycle after address
      if (load) begin
        pend_r <= 1'b1;
      end else if (done) begin
        pend_r <= 1'b0;
      end
      // RULE_05 RULE_13 retry until accepted
      vld_r <= pend_r & ~done;
      ready_r <= ~pend_r & ~load & ~busy_r & ~ready_r;
      // RULE_15 RULE_16 RULE_18 single pulses
      ref_r <= i_refresh & maint_ok & ~ref_r & ~cal_r;
      cal_r <= i_calibrate & maint_ok & ~ref_r & ~cal_r;
      if (ref_r | cal_r) begin
        busy_r <= 1'b1;
        ref_out_r <= ref_r;
        cal_out_r <= cal_r;
      end else if (ack) begin
        ref_out_r <= ref_out_r & ~bus.refresh_acknowledge;
        cal_out_r <= cal_out_r & ~bus.calibration_acknowledge;
        busy_r <= (ref_out_r & ~bus.refresh_acknowledge) | (cal_out_r & ~bus.calibration_acknowledge);
      end
      // RULE_08 data one cycle after fetch
      fetch_r <= bus.write_data_fetch;
      fptr_r <= bus.write_buffer_echo;
      wd_r <= i_wr_data;
      wm_r <= i_wr_mask;
      rv_r <= bus.read_data_valid;
      rp_r <= bus.read_buffer_echo;
      rdat_r <= bus.read_payload;
    end
  end
  assign bus.bank = cur_r.bank;
  assign bus.row = cur_r.row;
  assign bus.col = cur_r.col;
  assign bus.cmd = cur_r.cmd;
  assign bus.buffer_pointer_value = cur_r.ptr;
  assign bus.use_addr = vld_r;
  assign bus.write_payload = wd_r;
  assign bus.write_byte_mask = wm_r;
  assign bus.refresh_request = ref_r;
  assign bus.calibration_request = cal_r;
  assign o_req_ready = ready_r;
  assign o_maint_busy = busy_r;
  assign o_fetch = fetch_r;
  assign o_fetch_ptr = fptr_r;
  assign o_rd_valid = rv_r;
  assign o_rd_ptr = rp_r;
  assign o_rd_data = rdat_r;
endmodule

//--- verification/nri_monitor.sv
`timescale 1ns/1ps
module nri_monitor
  import nri_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic use_addr,
  input wire logic accept,
  input wire logic [`NRI_BANK_W-1:0] bank,
  input wire logic [`NRI_ROW_W-1:0] row,
  input wire logic [`NRI_COL_W-1:0] col,
  input wire logic [`NRI_CMD_W-1:0] cmd,
  input wire nri_buf_t buffer_pointer_value,
  input wire logic write_data_fetch,
  input wire logic read_data_valid,
  input wire logic refresh_request,
  input wire logic refresh_acknowledge,
  input wire logic calibration_request,
  input wire logic calibration_acknowledge
);
  logic [7:0] wr_pend_r;
  logic [7:0] rd_pend_r;
  wire take_w = use_addr && accept;
  wire take_wr_w = take_w && (cmd == `NRI_CMD_WRITE);
  wire take_rd_w = take_w && (cmd == `NRI_CMD_READ);
  // Outstanding writes and reads seen at the interface
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_r <= 8'h00;
      rd_pend_r <= 8'h00;
    end else begin
      wr_pend_r <= wr_pend_r + 8'(take_wr_w) - 8'(write_data_fetch);
      rd_pend_r <= rd_pend_r + 8'(take_rd_w) - 8'(read_data_valid);
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_cal_ack_pulse: assert property (calibration_acknowledge |=> !calibration_acknowledge)
    else $error("calibration acknowledge longer than one cycle");
  a_ref_ack_pulse: assert property (refresh_acknowledge |=> !refresh_acknowledge)
    else $error("refresh acknowledge longer than one cycle");
  a_cal_done_bound: assert property (calibration_request |-> ##[1:40] calibration_acknowledge)
    else $error("calibration never acknowledged");
  a_ref_done_bound: assert property (refresh_request |-> ##[1:40] refresh_acknowledge)
    else $error("refresh never acknowledged");
  a_addr_leads_valid: assert property ($rose(use_addr) |-> $stable({bank, row, col, cmd}))
    else $error("address changed with valid strobe");
  a_retry_holds_req: assert property (use_addr && !accept |=> use_addr && $stable({bank, row, col, cmd, buffer_pointer_value}))
    else $error("refused request not repeated unchanged");
  a_fetch_has_write: assert property (write_data_fetch |-> wr_pend_r != 8'h00)
    else $error("write fetch without pending write");
  a_rdvalid_has_read: assert property (read_data_valid |-> rd_pend_r != 8'h00)
    else $error("read data without pending read");
  c_back_to_back: cover property (take_w ##1 take_w);
  c_refused: cover property (use_addr && !accept);
  c_concurrent: cover property (write_data_fetch && read_data_valid);
  c_both_maint: cover property (refresh_request && calibration_request);
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
  import nri_pkg::*;
  logic i_clk_sys, i_rst, i_reorder_mode, i_req_valid, i_refresh, i_calibrate, i_mem_rd_valid;
  logic o_req_ready, o_maint_busy, o_fetch, o_rd_valid, o_mem_cmd_valid, o_mem_wr_valid;
  nri_req_t i_req;
  nri_data_t i_wr_data, i_mem_rd_data, o_rd_data, o_mem_wr_data, ed;
  nri_mask_t i_wr_mask, o_mem_wr_mask;
  nri_buf_t o_fetch_ptr, o_rd_ptr;
  logic [`NRI_CMD_W-1:0] o_mem_cmd;
  logic [`NRI_BANK_W-1:0] o_mem_bank;
  logic [`NRI_ROW_W-1:0] o_mem_row;
  logic [`NRI_COL_W-1:0] o_mem_col;
  integer seed = 28;
  int error_cnt, n_tests, pend, ref_acks, cal_acks, er, ec, c, w, i, m, k;
  nri_req_t req_of [int];
  nri_data_t wbuf [32];
  nri_mask_t wmsk [32];
  int issq[$], mrq[$], fq[$], wq[$], erp[$];
  nri_data_t erd[$];
  nri_if bus();
  nri_ctrl nri_ctrl_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reorder_mode(i_reorder_mode), .bus(bus),
    .o_mem_cmd_valid(o_mem_cmd_valid), .o_mem_cmd(o_mem_cmd), .o_mem_bank(o_mem_bank), .o_mem_row(o_mem_row),
    .o_mem_col(o_mem_col), .o_mem_wr_valid(o_mem_wr_valid), .o_mem_wr_data(o_mem_wr_data),
    .o_mem_wr_mask(o_mem_wr_mask), .i_mem_rd_valid(i_mem_rd_valid), .i_mem_rd_data(i_mem_rd_data));
  nri_user nri_user_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .bus(bus), .i_req_valid(i_req_valid),
    .o_req_ready(o_req_ready), .i_req(i_req), .i_refresh(i_refresh), .i_calibrate(i_calibrate),
    .o_maint_busy(o_maint_busy), .o_fetch(o_fetch), .o_fetch_ptr(o_fetch_ptr), .i_wr_data(i_wr_data),
    .i_wr_mask(i_wr_mask), .o_rd_valid(o_rd_valid), .o_rd_ptr(o_rd_ptr), .o_rd_data(o_rd_data));
  nri_monitor nri_monitor_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .use_addr(bus.use_addr),
    .accept(bus.accept), .bank(bus.bank), .row(bus.row), .col(bus.col), .cmd(bus.cmd),
    .buffer_pointer_value(bus.buffer_pointer_value), .write_data_fetch(bus.write_data_fetch),
    .read_data_valid(bus.read_data_valid), .refresh_request(bus.refresh_request),
    .refresh_acknowledge(bus.refresh_acknowledge), .calibration_request(bus.calibration_request),
    .calibration_acknowledge(bus.calibration_acknowledge));
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic int popq(ref int q[$]);
    if (q.size() == 0) return -1;
    return q.pop_front();
  endfunction
  task report_and_stop;
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Memory side model and result checks, settled values at the falling edge
  always @(negedge i_clk_sys) if (!i_rst) begin
    if (o_mem_cmd_valid) begin
      c = o_mem_col;
      if (!i_reorder_mode) chk("issue order", o_mem_col, popq(issq));
      chk("issue bank", o_mem_bank, req_of[c].bank);
      chk("issue row", o_mem_row, req_of[c].row);
      chk("issue cmd", o_mem_cmd, req_of[c].cmd);
      if (o_mem_cmd == `NRI_CMD_READ) mrq.push_back(c);
      else begin
        fq.push_back(req_of[c].ptr);
        wq.push_back(req_of[c].ptr);
      end
    end
    if (o_fetch) chk("fetch ptr", o_fetch_ptr, popq(fq));
    if (o_mem_wr_valid) begin
      w = popq(wq) & 31;
      chk("write data", o_mem_wr_data, wbuf[w]);
      chk("write mask", o_mem_wr_mask, wmsk[w]);
      pend--;
    end
    if (o_rd_valid) begin
      ed = erd.size() ? erd.pop_front() : 'x;
      chk("read ptr", o_rd_ptr, popq(erp));
      chk("read data", o_rd_data, ed);
      pend--;
    end
    ref_acks += bus.refresh_acknowledge;
    cal_acks += bus.calibration_acknowledge;
    i_mem_rd_data = {$random(seed), $random(seed)};
    i_mem_rd_valid = mrq.size() != 0 && ($random(seed) & 1);
    if (i_mem_rd_valid) begin
      c = mrq.pop_front();
      erp.push_back(req_of[c].ptr);
      erd.push_back(i_mem_rd_data);
    end
    i_wr_data = wbuf[bus.write_buffer_echo];
    i_wr_mask = wmsk[bus.write_buffer_echo];
  end
  task automatic send(input int id, input bit rd, input int gap);
    int t;
    nri_req_t r;
    if (gap > 0) begin
      i_req_valid = 0;
      repeat (gap) @(negedge i_clk_sys);
    end
    r = nri_req_t'({$random(seed), $random(seed)});
    r.col = `NRI_COL_W'(id);
    r.cmd = rd ? `NRI_CMD_READ : `NRI_CMD_WRITE;
    r.ptr = nri_buf_t'(id);
    wbuf[r.ptr] = {$random(seed), $random(seed)};
    wmsk[r.ptr] = nri_mask_t'($random(seed));
    req_of[id] = r;
    pend++;
    if (!i_reorder_mode) issq.push_back(id);
    i_req = r;
    i_req_valid = 1;
    t = 0;
    while (!o_req_ready && t < 200) begin
      @(negedge i_clk_sys);
      t++;
    end
    chk("request taken", t < 200, 1);
    @(negedge i_clk_sys);
  endtask
  task automatic drain;
    int t;
    i_req_valid = 0;
    t = 0;
    while ((pend != 0 || ref_acks < er || cal_acks < ec) && t < 2000) begin
      @(negedge i_clk_sys);
      t++;
    end
    chk("outstanding", pend, 0);
    chk("refresh acks", ref_acks, er);
    chk("calibration acks", cal_acks, ec);
    chk("maint busy", o_maint_busy, 0);
  endtask
  initial begin
    i_clk_sys = 0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  initial begin
    #40000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    {i_reorder_mode, i_req_valid, i_refresh, i_calibrate, i_mem_rd_valid} = '0;
    {i_req, i_wr_data, i_mem_rd_data, i_wr_mask} = '0;
    i_rst = 1;
    repeat (2) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_rst = 0;
    for (m = 0; m < 2; m++) begin
      i_reorder_mode = m[0];
      for (i = 0; i < 24; i++) send(m * 100 + i, $random(seed) & 1, ($random(seed) & 3) == 0 ? 2 : 0);
      drain();
    end
    for (k = 1; k < 4; k++) begin
      i_refresh = k[0];
      i_calibrate = k[1];
      er += k[0];
      ec += k[1];
      @(negedge i_clk_sys);
      i_refresh = 0;
      i_calibrate = 0;
      send(300 + k, k[0], 0);
      drain();
    end
    report_and_stop();
  end
endmodule
